// File: adcso_pkg.sv
// shared constants and types of the serial output and calibration block
package adcso_pkg;
    // conversion word and buffer shape
    localparam int unsigned WORD_BITS = 20;
    localparam int unsigned FIFO_DEPTH = 2;

    // master clock figures
    localparam int unsigned BLANK_CYC = 4; // word_ready_n high before a fresh word
    localparam int unsigned CAL_RST_CYC = 4; // strobe longer than this resets the device
    localparam int unsigned CAL_CYC_DEF = 64; // length of a calibration run
    localparam int unsigned SSC_DIV = 4; // self-clocked sclk = clk / SSC_DIV

    // phases of the self-clocked divider, high for one phase in four
    localparam logic [1:0] SSC_HIGH_PH = 2'h0;
    localparam logic [1:0] SSC_FALL_PH = 2'h1;
    localparam logic [1:0] SSC_LAST_PH = 2'h3;

    // calibration points after reset
    localparam logic [WORD_BITS-1:0] ZERO_RST = 20'h0_0000;
    localparam logic [WORD_BITS-1:0] FULL_RST = 20'hF_FFFF;

    // positions in the synchroniser vector
    localparam int unsigned SY_CS = 0;
    localparam int unsigned SY_MODE = 1;
    localparam int unsigned SY_POL = 2;
    localparam int unsigned SY_SELA = 3;
    localparam int unsigned SY_SELB = 4;
    localparam int unsigned SY_CAL = 5;
    localparam int unsigned SY_SLEEP = 6;
    localparam int unsigned SY_DONE = 7;
    localparam int unsigned SY_TGL = 8;
    localparam int unsigned SY_N = 9;
    localparam logic [SY_N-1:0] SY_RST = 9'h041; // cs_n and sleep_n idle high

    // frame sequencer and calibration sequencer
    typedef enum logic [2:0] {F_EMPTY, F_BLANK, F_HAVE, F_SSC, F_SEC} adcso_frame_t;
    typedef enum logic [1:0] {C_IDLE, C_HOLD, C_RUN} adcso_cal_st_t;

    // calibration type caught at the strobe rise
    typedef struct packed {
        logic system;
        logic full_step;
    } adcso_cal_t;

    // registered pin drive of the serial port
    typedef struct packed {
        logic data;
        logic data_oe;
        logic clk;
        logic clk_oe;
    } adcso_pins_t;
endpackage : adcso_pkg

// File: adcso_top.sv
// serial output port, word buffer and calibration control of the converter
`timescale 1ns/1ps
module adcso_top
    import adcso_pkg::*;
#(
    parameter int unsigned W = WORD_BITS,
    parameter int unsigned DEPTH = FIFO_DEPTH,
    parameter int unsigned CAL_CYC = CAL_CYC_DEF
) (
    // master clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // conversion words from the filter
    input wire logic [W-1:0] conv_data,
    input wire logic conv_valid,
    output logic conv_ready,
    // serial port pins
    input wire logic cs_n,
    input wire logic serial_mode,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    output logic serial_out,
    output logic serial_out_oe,
    output logic word_ready_n,
    // control pins
    input wire logic polarity_select,
    input wire logic trim_sel_a,
    input wire logic trim_sel_b,
    input wire logic cal_strobe,
    input wire logic sleep_n,
    // calibration status
    output logic cal_busy,
    output adcso_cal_t cal_kind,
    output logic [W-1:0] zero_point,
    output logic [W-1:0] full_point
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam int unsigned BW = $clog2(W + 1);
    localparam int unsigned KW = $clog2(CAL_CYC + CAL_RST_CYC + 2);

    logic [SY_N-1:0] sy_in;
    logic [SY_N-1:0] sy1_q;
    logic [SY_N-1:0] sy2_q;
    logic [SY_N-1:0] sy3_q;
    logic [BW-1:0] idx_l_q, idx_l_d;
    logic tgl_l_q, done_l_q, done_l_d;
    logic lrst;
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, push, pop;
    adcso_frame_t fst_q, fst_d;
    logic [W-1:0] hold_q, hold_d;
    logic [BW-1:0] bit_q, bit_d;
    logic [1:0] div_q, div_d;
    logic [2:0] blank_q, blank_d;
    logic stop_q, stop_d, ign_q, ign_d, run_q, run_d, seen_q, seen_d, wrn_q, wrn_d;
    adcso_pins_t pins_q, pins_d;
    adcso_cal_st_t cst_q, cst_d;
    logic [KW-1:0] ccnt_q, ccnt_d;
    adcso_cal_t kind_q, kind_d;
    logic [W-1:0] zero_q, zero_d, full_q, full_d, raw_q, raw_d;
    logic cbusy_q, cbusy_d, dev_rst, cs_lo, cs_fall, cal_rise, sec_bit;

    // pins and link flags cross in through two flops each; a third flop gives their edges
    assign sy_in = {tgl_l_q, done_l_q, sleep_n, cal_strobe, trim_sel_b, trim_sel_a,
                    polarity_select, serial_mode, cs_n};
    generate
        for (genvar i = 0; i < SY_N; i++) begin : g_sync
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sy1_q[i] <= SY_RST[i];
                    sy2_q[i] <= SY_RST[i];
                    sy3_q[i] <= SY_RST[i];
                end else begin
                    sy1_q[i] <= sy_in[i];
                    sy2_q[i] <= sy1_q[i];
                    sy3_q[i] <= sy2_q[i];
                end
            end
        end
    endgenerate

    assign cs_lo = !sy2_q[SY_CS];
    assign cs_fall = sy3_q[SY_CS] && !sy2_q[SY_CS];
    assign cal_rise = sy2_q[SY_CAL] && !sy3_q[SY_CAL];
    // long strobe and running calibration hold the port in reset
    assign dev_rst = (cst_q == C_RUN) || (cst_q == C_HOLD && ccnt_q > KW'(CAL_RST_CYC));

    // link side: counts host sclk falls, held in reset outside a frame
    assign lrst = sys_rst | ~run_q;
    always_comb begin
        idx_l_d = (idx_l_q == BW'(W)) ? idx_l_q : idx_l_q + BW'(1);
        done_l_d = (idx_l_d == BW'(W));
    end

    // new bit on each falling edge of the host clock
    always_ff @(negedge sclk_in or posedge lrst) begin
        if (lrst) begin
            idx_l_q <= '0;
            tgl_l_q <= 1'b0;
            done_l_q <= 1'b0;
        end else begin
            idx_l_q <= idx_l_d;
            tgl_l_q <= ~tgl_l_q;
            done_l_q <= done_l_d;
        end
    end

    // hold_q stays still through the frame, so the link reads it directly
    assign sec_bit = (idx_l_q < BW'(W)) ? hold_q[W - 1 - int'(idx_l_q)] : 1'b0;

    // coding of a raw sample against the calibration points
    function automatic logic [W-1:0] code_word(input logic [W-1:0] raw, input logic bip,
                                               input logic [W-1:0] zero,
                                               input logic [W-1:0] full);
        logic signed [W:0] diff;
        logic [W-1:0] res;
        diff = $signed({raw[W-1], raw}) - $signed({zero[W-1], zero});
        res = '0;
        if (bip) begin
            // saturate the signed offset, then flip the sign bit
            if (diff > $signed({2'b00, {(W - 1){1'b1}}})) begin
                res = {1'b0, {(W - 1){1'b1}}};
            end else if (diff < $signed({2'b11, {(W - 1){1'b0}}})) begin
                res = {1'b1, {(W - 1){1'b0}}};
            end else begin
                res = diff[W-1:0];
            end
            res[W-1] = ~res[W-1];
        end else if (raw < zero) begin
            res = '0;
        end else if (raw >= full) begin
            res = '1;
        end else begin
            res = raw - zero;
        end
        return res;
    endfunction

    // two-entry word buffer; drains only between frames so a slow reader stalls it
    assign push = conv_valid && rdy_q;
    assign pop = (cnt_q != '0) && !dev_rst && sy2_q[SY_SLEEP]
                 && (fst_q == F_EMPTY || fst_q == F_HAVE);
    always_comb begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (dev_rst) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                mem_d[wp_q] = code_word(conv_data, sy2_q[SY_POL], zero_q, full_q);
                wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
            end
            if (pop) begin
                rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
            end
            cnt_d = cnt_q + CW'(push) - CW'(pop);
        end
        rdy_d = (cnt_d != CW'(DEPTH)) && !dev_rst && sy2_q[SY_SLEEP];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // frame sequencer: word hand-over, chip select and both clocking modes
    always_comb begin
        fst_d = fst_q;
        hold_d = hold_q;
        bit_d = bit_q;
        div_d = div_q;
        blank_d = blank_q;
        stop_d = stop_q;
        ign_d = cs_lo ? ign_q : 1'b0;
        run_d = run_q;
        seen_d = seen_q;
        wrn_d = wrn_q;
        pins_d = pins_q;
        unique case (fst_q)
            F_EMPTY: begin
                wrn_d = 1'b1;
                if (pop) begin
                    hold_d = mem_q[rp_q];
                    blank_d = '0;
                    fst_d = F_BLANK;
                end
            end
            F_BLANK: begin
                if (cs_fall) begin
                    ign_d = 1'b1;
                end
                if (blank_q == 3'(BLANK_CYC - 1)) begin
                    wrn_d = 1'b0;
                    fst_d = F_HAVE;
                end else begin
                    blank_d = blank_q + 3'h1;
                end
            end
            F_HAVE: begin
                if (pop) begin
                    // an unread word is replaced by the next update
                    hold_d = mem_q[rp_q];
                    wrn_d = 1'b1;
                    blank_d = '0;
                    fst_d = F_BLANK;
                end else if (cs_lo && !ign_q && sy2_q[SY_SLEEP]) begin
                    stop_d = 1'b0;
                    bit_d = '0;
                    pins_d.data_oe = 1'b1;
                    if (sy2_q[SY_MODE]) begin
                        fst_d = F_SSC;
                        div_d = SSC_LAST_PH;
                        pins_d.data = hold_q[W-1];
                        pins_d.clk = 1'b0;
                        pins_d.clk_oe = 1'b1;
                    end else begin
                        fst_d = F_SEC;
                        run_d = 1'b1;
                    end
                end
            end
            F_SSC: begin
                div_d = div_q + 2'h1;
                pins_d.clk = (div_d == SSC_HIGH_PH);
                if (!cs_lo) begin
                    stop_d = 1'b1;
                end
                if (div_d == SSC_FALL_PH) begin
                    // each bit ends at the clock fall, so an abort waits for it
                    if (bit_q == BW'(W - 1) || stop_q) begin
                        fst_d = F_EMPTY;
                        wrn_d = 1'b1;
                        pins_d = '0;
                    end else begin
                        bit_d = bit_q + BW'(1);
                        pins_d.data = hold_q[W - 2 - int'(bit_q)];
                    end
                end
            end
            F_SEC: begin
                if (!cs_lo && !stop_q) begin
                    stop_d = 1'b1;
                    seen_d = sy2_q[SY_TGL];
                end
                // release after the last bit, or after the bit in progress
                if (sy2_q[SY_DONE] || (stop_q && sy2_q[SY_TGL] != seen_q)) begin
                    fst_d = F_EMPTY;
                    wrn_d = 1'b1;
                    run_d = 1'b0;
                    pins_d = '0;
                end
            end
        endcase
        if (dev_rst) begin
            fst_d = F_EMPTY;
            wrn_d = 1'b1;
            run_d = 1'b0;
            pins_d = '0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fst_q <= F_EMPTY;
            hold_q <= '0;
            bit_q <= '0;
            div_q <= '0;
            blank_q <= '0;
            stop_q <= 1'b0;
            ign_q <= 1'b0;
            run_q <= 1'b0;
            seen_q <= 1'b0;
            wrn_q <= 1'b1;
            pins_q <= '0;
        end else begin
            fst_q <= fst_d;
            hold_q <= hold_d;
            bit_q <= bit_d;
            div_q <= div_d;
            blank_q <= blank_d;
            stop_q <= stop_d;
            ign_q <= ign_d;
            run_q <= run_d;
            seen_q <= seen_d;
            wrn_q <= wrn_d;
            pins_q <= pins_d;
        end
    end

    // calibration sequencer: strobe length, type capture and point recording
    always_comb begin
        cst_d = cst_q;
        ccnt_d = ccnt_q;
        kind_d = kind_q;
        zero_d = zero_q;
        full_d = full_q;
        raw_d = conv_valid ? conv_data : raw_q;
        unique case (cst_q)
            C_IDLE: begin
                if (cal_rise) begin
                    kind_d.system = !sy2_q[SY_SELB];
                    kind_d.full_step = sy2_q[SY_SELA];
                    ccnt_d = KW'(1);
                    cst_d = C_HOLD;
                end
            end
            C_HOLD: begin
                if (sy2_q[SY_CAL]) begin
                    ccnt_d = (ccnt_q > KW'(CAL_RST_CYC)) ? ccnt_q : ccnt_q + KW'(1);
                end else if (ccnt_q > KW'(CAL_RST_CYC)) begin
                    ccnt_d = KW'(CAL_CYC);
                    cst_d = C_RUN;
                end else begin
                    // a short strobe only synchronises, nothing is reset
                    cst_d = C_IDLE;
                end
            end
            C_RUN: begin
                if (ccnt_q <= KW'(1)) begin
                    cst_d = C_IDLE;
                    if (!kind_q.system) begin
                        zero_d = ZERO_RST;
                        full_d = FULL_RST;
                    end else if (kind_q.full_step) begin
                        full_d = raw_q;
                    end else begin
                        zero_d = raw_q;
                    end
                end else begin
                    ccnt_d = ccnt_q - KW'(1);
                end
            end
        endcase
        cbusy_d = (cst_d == C_RUN);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cst_q <= C_IDLE;
            ccnt_q <= '0;
            kind_q <= '0;
            zero_q <= ZERO_RST;
            full_q <= FULL_RST;
            raw_q <= '0;
            cbusy_q <= 1'b0;
        end else begin
            cst_q <= cst_d;
            ccnt_q <= ccnt_d;
            kind_q <= kind_d;
            zero_q <= zero_d;
            full_q <= full_d;
            raw_q <= raw_d;
            cbusy_q <= cbusy_d;
        end
    end

    // outputs; external-mode data comes from the link count, not a clk flop
    assign conv_ready = rdy_q;
    assign sclk_out = pins_q.clk;
    assign sclk_oe = pins_q.clk_oe;
    assign serial_out = pins_q.data_oe && ((fst_q == F_SEC) ? sec_bit : pins_q.data);
    assign serial_out_oe = pins_q.data_oe;
    assign word_ready_n = wrn_q;
    assign cal_busy = cbusy_q;
    assign cal_kind = kind_q;
    assign zero_point = zero_q;
    assign full_point = full_q;
endmodule : adcso_top

// File: adcso_top_assertions.sv
// concurrent checks on the serial port and calibration pins
`timescale 1ns/1ps
module adcso_top_assertions
    import adcso_pkg::*;
#(
    parameter int unsigned W = WORD_BITS
) (
    // clock, reset, word input
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] conv_data,
    input wire logic conv_valid,
    input wire logic conv_ready,
    // serial port
    input wire logic cs_n,
    input wire logic serial_mode,
    input wire logic sclk_in,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic word_ready_n,
    // control and status
    input wire logic polarity_select,
    input wire logic trim_sel_a,
    input wire logic trim_sel_b,
    input wire logic cal_strobe,
    input wire logic sleep_n,
    input wire logic cal_busy,
    input wire adcso_cal_t cal_kind,
    input wire logic [W-1:0] zero_point,
    input wire logic [W-1:0] full_point
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // self clock: one high phase, three low, then high again unless released
    a_sclk_duty: assert property ($rose(sclk_out) |=> !sclk_out [*3] ##1 (sclk_out || !sclk_oe))
        else $error("self clock period or duty wrong");
    a_bit_on_fall: assert property (sclk_oe && $past(sclk_oe) && $changed(serial_out) |-> $fell(sclk_out))
        else $error("serial data moved away from a clock fall");
    a_start_after_cs: assert property ($rose(serial_out_oe) |-> !word_ready_n && !$past(cs_n, 3))
        else $error("frame started without word or chip select");
    a_end_release: assert property ($fell(serial_out_oe) |-> word_ready_n && !sclk_oe)
        else $error("frame ended but word still flagged");
    a_blank_hold: assert property ($rose(word_ready_n) |-> word_ready_n [*4])
        else $error("ready blank shorter than four cycles");
    a_cal_stall: assert property (cal_busy |-> !conv_ready && !serial_out_oe)
        else $error("traffic during calibration");
    // kind caught from the select pins when the strobe rises
    a_kind_catch: assert property ($rose(cal_strobe) ##1 ($stable(trim_sel_a) && $stable(trim_sel_b)) [*4]
        |-> cal_kind.system == !trim_sel_b && cal_kind.full_step == trim_sel_a)
        else $error("calibration kind not taken from selects");
    a_long_strobe: assert property (cal_strobe [*6] ##1 !cal_strobe |-> ##[1:6] cal_busy)
        else $error("long strobe did not start calibration");

    // main scenarios reached
    cover property ($rose(sclk_oe));
    cover property ($rose(serial_out_oe) && !serial_mode);
    cover property ($fell(cal_busy));
endmodule : adcso_top_assertions

bind adcso_top adcso_top_assertions #(.W(W)) chk_i (
    .clk(clk), .sys_rst(sys_rst), .conv_data(conv_data), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .cs_n(cs_n), .serial_mode(serial_mode), .sclk_in(sclk_in),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .word_ready_n(word_ready_n),
    .polarity_select(polarity_select), .trim_sel_a(trim_sel_a), .trim_sel_b(trim_sel_b),
    .cal_strobe(cal_strobe), .sleep_n(sleep_n), .cal_busy(cal_busy), .cal_kind(cal_kind),
    .zero_point(zero_point), .full_point(full_point));

// File: adcso_host.sv
// host model reading the serial port in either clocking mode
`timescale 1ns/1ps
module adcso_host (
    // master clock for pacing
    input wire logic clk,
    // serial port
    output logic cs_n,
    output logic sclk_in,
    input wire logic sclk_out,
    input wire logic serial_out
);
    // link clock stands still outside frames
    initial begin
        cs_n = 1'b1;
        sclk_in = 1'b0;
    end

    // chip select moves only at a master clock edge
    task automatic set_cs(input logic v);
        @(posedge clk);
        cs_n <= v;
    endtask : set_cs

    // read msb first; a short count drops chip select mid-frame
    task automatic read_word(input logic self_mode, input int nbits, output logic [19:0] w);
        w = 20'h0_0000;
        set_cs(1'b0);
        if (!self_mode) begin
            // chip select may take four master cycles plus 160 ns to be seen
            repeat (4) @(posedge clk);
            #163;
        end
        for (int i = 0; i < nbits; i++) begin
            if (self_mode) begin
                @(posedge sclk_out);
                #1 w[19-i] = serial_out; // device clocks the frame
            end else begin
                sclk_in = 1'b1;
                w[19-i] = serial_out; // settled since the last fall
                #7.5 sclk_in = 1'b0;
                #7.5;
            end
        end
        // full word: let the release settle before chip select goes
        if (nbits == 20) repeat (5) @(posedge clk);
        set_cs(1'b1);
    endtask : read_word
endmodule : adcso_host

// File: adcso_top_bench.sv
// self-checking bench for the serial output and calibration block
`timescale 1ns/1ps
module adcso_top_bench;
    import adcso_pkg::*;
    // pol, self mode, raw word, expected serial word
    typedef logic [41:0] adcso_row_t;
    localparam adcso_row_t ROWS [7] = '{
        {2'h0, 20'h0_0000, 20'h0_0000}, {2'h1, 20'hF_FFFF, 20'hF_FFFF},
        {2'h2, 20'h7_FFFF, 20'hF_FFFF}, {2'h3, 20'h8_0000, 20'h0_0000},
        {2'h2, 20'h0_0000, 20'h8_0000}, {2'h1, 20'h1_2345, 20'h1_2345},
        {2'h3, 20'hF_FFFF, 20'h7_FFFF}};
    logic clk, sys_rst, conv_valid, serial_mode, polarity_select, saw_busy;
    logic trim_sel_a, trim_sel_b, cal_strobe, conv_ready, cs_n, sclk_in, sclk_out;
    logic sclk_oe, serial_out, serial_out_oe, word_ready_n, cal_busy, sleep_n;
    logic [19:0] conv_data, zero_point, full_point, w;
    adcso_cal_t cal_kind;
    int n_mismatch = 0;
    int checks_done = 0;

    // short calibration run keeps the bench quick
    adcso_top #(.CAL_CYC(8)) dut (
        .clk(clk), .sys_rst(sys_rst), .conv_data(conv_data), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .cs_n(cs_n), .serial_mode(serial_mode), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .word_ready_n(word_ready_n),
        .polarity_select(polarity_select), .trim_sel_a(trim_sel_a), .trim_sel_b(trim_sel_b),
        .cal_strobe(cal_strobe), .sleep_n(sleep_n), .cal_busy(cal_busy), .cal_kind(cal_kind),
        .zero_point(zero_point), .full_point(full_point));
    adcso_host host (.clk(clk), .cs_n(cs_n), .sclk_in(sclk_in), .sclk_out(sclk_out),
        .serial_out(serial_out));

    // master clock never stops while awake
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (cal_busy === 1'b1) saw_busy <= 1'b1;

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // offer one word, held until the block takes it
    task automatic send(input logic [19:0] d);
        logic r;
        int n;
        n = 0;
        @(posedge clk);
        conv_data <= d;
        conv_valid <= 1'b1;
        do begin
            #1 r = conv_ready;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 300);
        conv_valid <= 1'b0;
        // a word never taken is a hang, not a pass
        if (r !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : send

    task automatic wait_rdy;
        int n;
        n = 0;
        while (word_ready_n !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : wait_rdy

    // mode pins, one word, one full frame; an old held word may linger, so skip its blank
    task automatic xfer(input logic [1:0] pm, input logic [19:0] raw, input logic [19:0] exp);
        @(posedge clk);
        polarity_select <= pm[1];
        serial_mode <= pm[0];
        repeat (3) @(posedge clk);
        send(raw);
        repeat (2) @(posedge clk);
        wait_rdy();
        host.read_word(pm[0], 20, w);
        chk(w, exp);
        repeat (2) @(posedge clk);
        #1 chk({18'h0_0000, word_ready_n, serial_out_oe}, 20'h0_0002);
    endtask : xfer

    // strobe for hold cycles with the select pins and a level on the input
    task automatic cal(input logic a, input logic b, input logic [19:0] d, input int hold);
        @(posedge clk);
        {trim_sel_a, trim_sel_b, conv_data, conv_valid, saw_busy} <= {a, b, d, 2'h2};
        @(posedge clk);
        cal_strobe <= 1'b1;
        repeat (hold) @(posedge clk);
        // input level already caught; stop offering so no stale words queue up
        {cal_strobe, conv_valid} <= 2'h0;
        repeat (20) @(posedge clk);
        #1 chk({18'h0_0000, cal_kind}, {18'h0_0000, !b, a});
        chk({19'h0_0000, saw_busy}, {19'h0_0000, hold > 4});
    endtask : cal

    initial begin
        {sys_rst, conv_valid, serial_mode, polarity_select, saw_busy} = 5'h10;
        sleep_n = 1'b1;
        {trim_sel_a, trim_sel_b, cal_strobe, conv_data} = 23'h0_0000;
        repeat (8) @(posedge clk);
        #1 chk({16'h0000, conv_ready, word_ready_n, serial_out_oe, sclk_oe}, 20'h0_0004);
        chk(full_point ^ zero_point, FULL_RST ^ ZERO_RST);
        @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ROWS[i]) xfer(ROWS[i][41:40], ROWS[i][39:20], ROWS[i][19:0]);
        // fill the buffer behind a running frame; newest word survives
        xfer(2'h1, 20'h0_1111, 20'h0_1111);
        send(20'h0_1111);
        wait_rdy();
        fork
            host.read_word(1'b1, 20, w);
            begin
                repeat (8) @(posedge clk);
                send(20'h0_2222);
                send(20'h0_3333);
                #1 chk({19'h0_0000, conv_ready}, 20'h0_0000);
            end
        join
        chk(w, 20'h0_1111);
        repeat (20) @(posedge clk);
        wait_rdy();
        host.read_word(1'b1, 20, w);
        chk(w, 20'h0_3333);
        // abort after five bits: bit finished, lines released, word dropped
        send(20'hA_5555);
        wait_rdy();
        host.read_word(1'b1, 5, w);
        repeat (10) @(posedge clk);
        #1 chk({12'h000, w[19:15], word_ready_n, serial_out_oe, sclk_oe}, 20'h0_00A4);
        // chip select falling inside the blank is ignored until it rises again
        xfer(2'h0, 20'h0_0001, 20'h0_0001);
        send(20'h6_789A);
        host.set_cs(1'b0);
        wait_rdy();
        repeat (6) @(posedge clk);
        #1 chk({19'h0_0000, serial_out_oe}, 20'h0_0000);
        host.set_cs(1'b1);
        repeat (3) @(posedge clk);
        host.read_word(1'b0, 20, w);
        chk(w, 20'h6_789A);
        // system calibration, zero then full, then coding against the new points
        cal(1'b0, 1'b0, 20'h0_0100, 6);
        cal(1'b1, 1'b0, 20'h0_0500, 6);
        chk(zero_point, 20'h0_0100);
        chk(full_point, 20'h0_0500);
        xfer(2'h0, 20'h0_0300, 20'h0_0200);
        xfer(2'h1, 20'h0_0050, 20'h0_0000);
        xfer(2'h0, 20'h0_0600, 20'hF_FFFF);
        xfer(2'h2, 20'h0_0000, 20'h7_FF00);
        cal(1'b0, 1'b1, 20'h0_0000, 6);
        chk(full_point ^ zero_point, FULL_RST ^ ZERO_RST);
        cal(1'b1, 1'b1, 20'h0_0000, 3);
        // sleep refuses new words at the input
        @(posedge clk);
        #1 chk({19'h0_0000, conv_ready}, 20'h0_0001);
        @(posedge clk);
        sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({19'h0_0000, conv_ready}, 20'h0_0000);
        wrap_up();
    end

    // cut a hang short
    initial begin
        #400_000;
        n_mismatch++;
        wrap_up();
    end
endmodule : adcso_top_bench
